// *** include/wmc_map.svh ***
`ifndef WMC_MAP_SVH
`define WMC_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define WMC_OFS_PHASE_CONFIG 8'h37
`define WMC_OFS_PHASE_REFERENCE 8'h38
`define WMC_OFS_PHASE_AVERAGE 8'h39
`define WMC_OFS_PHASE_RESULT 8'h3a
`define WMC_OFS_CAP_CONFIG 8'h3b
`define WMC_OFS_CAP_REFERENCE 8'h3c
`define WMC_OFS_CAP_AVERAGE 8'h3d
`define WMC_OFS_CAP_RESULT 8'h3e
`define WMC_OFS_CHIP_IDENTITY 8'h3f
`define WMC_OFS_IRQ_STATUS 8'h40
`define WMC_OFS_IRQ_MASK 8'h41

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define WMC_CFG_DELTA_MSB 7
`define WMC_CFG_DELTA_LSB 4
`define WMC_CFG_INCLUDE_BIT 3
`define WMC_CFG_WEIGHT_MSB 2
`define WMC_CFG_WEIGHT_LSB 1
`define WMC_CFG_REFSEL_BIT 0
`define WMC_IRQ_PHASE_BIT 0
`define WMC_IRQ_CAP_BIT 1
`define WMC_RESET_BYTE 8'h00
`define WMC_IRQ_RESET 2'h0

`endif

// *** include/wmc_pkg.sv ***
package wmc_pkg;

  // Configuration byte layout shared by phase and capacitance channels
  typedef struct packed {
    logic [3:0] delta_threshold;
    logic avg_include_trigger;
    logic [1:0] avg_weight;
    logic reference_select;
  } wmc_cfg_t;

  // One measurement result handed in by a front end
  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } wmc_meas_t;

  typedef enum logic [1:0] {
    WMC_CH_PHASE,
    WMC_CH_CAP
  } wmc_channel_t;

endpackage

// *** hw/wmc_regs.sv ***
// How it works
// RULE1: Cap config upper nibble is delta; exceeding it raises cap wake interrupt.
// RULE2: Include bit decides whether an interrupting measurement enters the average.
// RULE3: Weight code 00/01/10/11 divides update by 4/8/16/32.
// RULE4: Reference select picks software reference (0) or running average (1).
// RULE5: Cap reference register at 3Ch, read-write, resets to zero.
// RULE6: Cap average at 3Dh, read-only, resets to zero.
// RULE7: Cap last result at 3Eh, read-only, resets to zero.
// RULE8: Phase reference register at 38h, read-write, resets to zero.
// RULE9: Phase average at 39h, read-only, resets to zero.
// RULE10: Phase last result at 3Ah, read-only, resets to zero.
// RULE11: Identity at 3Fh: type code bits 7..3, revision bits 2..0.
// RULE12: Phase config at 37h mirrors cap fields and governs phase channel.
// RULE13: Cap measurement at each wake timeout; interrupt if over threshold.
// RULE14: Accepted result moves average by difference over weight; last result refreshed.
// RULE15: Writes to result and identity registers are ignored.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "wmc_map.svh"

module wmc_regs
  import wmc_pkg::*;
#(
  parameter logic [4:0] CHIP_TYPE = 5'h11, // Arbitrary value
  parameter logic [2:0] CHIP_REV = 3'h1 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Measurement inputs, one-cycle valid from the front ends
  input wire wmc_meas_t phase_meas,
  input wire wmc_meas_t cap_meas,
  // Wake enables and configuration outputs for the measurement sequencer
  input wire logic cap_wake_enable,
  input wire logic phase_wake_enable,
  output wmc_cfg_t phase_cfg_out,
  output wmc_cfg_t cap_cfg_out,
  // Interrupt
  output logic irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Shift for weight code: 4,8,16,32 are shifts of 2..5
  function automatic logic [2:0] weight_shift(input logic [1:0] code);
    weight_shift = {1'b0, code} + 3'h2; // [RULE3]
  endfunction

  // Signed step toward the new result by difference / weight
  function automatic logic [7:0] next_average(input logic [7:0] avg, input logic [7:0] res,
                                              input logic [1:0] code);
    logic signed [9:0] diff;
    logic signed [9:0] step;
    diff = $signed({2'b00, res}) - $signed({2'b00, avg});
    step = diff >>> weight_shift(code);
    next_average = 8'(avg + step[7:0]); // [RULE14]
  endfunction

  // Absolute difference of two bytes
  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  wmc_cfg_t phase_cfg;
  wmc_cfg_t cap_cfg;
  logic [7:0] phase_reference_value;
  logic [7:0] phase_average_value;
  logic [7:0] phase_last_result;
  logic [7:0] cap_reference_value;
  logic [7:0] cap_average_value;
  logic [7:0] cap_last_result;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire wr_phase_cfg = reg_write && reg_addr == `WMC_OFS_PHASE_CONFIG; // [RULE12]
  wire wr_phase_ref = reg_write && reg_addr == `WMC_OFS_PHASE_REFERENCE; // [RULE8]
  wire wr_cap_cfg = reg_write && reg_addr == `WMC_OFS_CAP_CONFIG;
  wire wr_cap_ref = reg_write && reg_addr == `WMC_OFS_CAP_REFERENCE; // [RULE5]
  wire wr_irq_status = reg_write && reg_addr == `WMC_OFS_IRQ_STATUS;
  wire wr_irq_mask = reg_write && reg_addr == `WMC_OFS_IRQ_MASK;
  // Result and identity offsets have no write decode at all [RULE15]

  // ****************************************************************
  // Compare and averaging
  // ****************************************************************

  // Reference selection per channel
  wire [7:0] phase_ref_used = phase_cfg.reference_select ? phase_average_value
                                                         : phase_reference_value; // [RULE4]
  wire [7:0] cap_ref_used = cap_cfg.reference_select ? cap_average_value
                                                     : cap_reference_value; // [RULE4]

  // Threshold compare, strictly greater than delta
  wire phase_over = abs_diff(phase_meas.value, phase_ref_used) >
                    {4'h0, phase_cfg.delta_threshold}; // [RULE12]
  wire cap_over = abs_diff(cap_meas.value, cap_ref_used) >
                  {4'h0, cap_cfg.delta_threshold}; // [RULE1]

  // Wake events only while the wake measurement is enabled
  wire phase_event = phase_meas.valid && phase_wake_enable && phase_over;
  wire cap_event = cap_meas.valid && cap_wake_enable && cap_over; // [RULE13]

  // A triggering measurement joins the average only when include is set
  wire phase_accept = phase_meas.valid && (!phase_over || phase_cfg.avg_include_trigger);
  wire cap_accept = cap_meas.valid && (!cap_over || cap_cfg.avg_include_trigger); // [RULE2]

  wire [7:0] next_phase_average = next_average(phase_average_value, phase_meas.value,
                                               phase_cfg.avg_weight);
  wire [7:0] next_cap_average = next_average(cap_average_value, cap_meas.value,
                                             cap_cfg.avg_weight); // [RULE3]

  // Set wins over a simultaneous write-one clear
  wire [1:0] irq_set = {cap_event, phase_event};
  wire [1:0] next_irq_status = (irq_status & ~(wr_irq_status ? reg_wdata[1:0] : 2'h0)) |
                               irq_set;

  // ****************************************************************
  // Software registers
  // ****************************************************************

  // Configuration and references, reset to zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_cfg <= `WMC_RESET_BYTE;
      cap_cfg <= `WMC_RESET_BYTE;
      phase_reference_value <= `WMC_RESET_BYTE; // [RULE8]
      cap_reference_value <= `WMC_RESET_BYTE; // [RULE5]
      irq_mask <= `WMC_IRQ_RESET;
    end else begin
      if (wr_phase_cfg) phase_cfg <= reg_wdata;
      if (wr_cap_cfg) cap_cfg <= reg_wdata; // [RULE1]
      if (wr_phase_ref) phase_reference_value <= reg_wdata;
      if (wr_cap_ref) cap_reference_value <= reg_wdata;
      if (wr_irq_mask) irq_mask <= reg_wdata[1:0];
    end
  end

  // ****************************************************************
  // Measurement state
  // ****************************************************************

  // Phase channel: last result always refreshed, average only when accepted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_last_result <= `WMC_RESET_BYTE; // [RULE10]
      phase_average_value <= `WMC_RESET_BYTE; // [RULE9]
    end else if (phase_meas.valid) begin
      phase_last_result <= phase_meas.value;
      if (phase_accept) phase_average_value <= next_phase_average; // [RULE12]
    end
  end

  // Capacitance channel
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_last_result <= `WMC_RESET_BYTE; // [RULE7]
      cap_average_value <= `WMC_RESET_BYTE; // [RULE6]
    end else if (cap_meas.valid) begin
      cap_last_result <= cap_meas.value; // [RULE14]
      if (cap_accept) cap_average_value <= next_cap_average; // [RULE2]
    end
  end

  // Sticky interrupt status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= `WMC_IRQ_RESET;
    end else begin
      irq_status <= next_irq_status; // [RULE13]
    end
  end

  assign irq = |(irq_status & irq_mask);
  assign phase_cfg_out = phase_cfg;
  assign cap_cfg_out = cap_cfg;

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Read mux; unmapped offsets read zero
  logic [7:0] read_mux;
  always_comb begin
    case (reg_addr)
      `WMC_OFS_PHASE_CONFIG: read_mux = phase_cfg;
      `WMC_OFS_PHASE_REFERENCE: read_mux = phase_reference_value;
      `WMC_OFS_PHASE_AVERAGE: read_mux = phase_average_value; // [RULE9]
      `WMC_OFS_PHASE_RESULT: read_mux = phase_last_result; // [RULE10]
      `WMC_OFS_CAP_CONFIG: read_mux = cap_cfg;
      `WMC_OFS_CAP_REFERENCE: read_mux = cap_reference_value;
      `WMC_OFS_CAP_AVERAGE: read_mux = cap_average_value; // [RULE6]
      `WMC_OFS_CAP_RESULT: read_mux = cap_last_result; // [RULE7]
      `WMC_OFS_CHIP_IDENTITY: read_mux = {CHIP_TYPE, CHIP_REV}; // [RULE11]
      `WMC_OFS_IRQ_STATUS: read_mux = {6'h00, irq_status};
      `WMC_OFS_IRQ_MASK: read_mux = {6'h00, irq_mask};
      default: read_mux = 8'h00;
    endcase
  end

  // Read data is registered, valid only the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? read_mux : 8'h00;
    end
  end

endmodule // wmc_regs
`default_nettype wire

// *** bench/wmc_regs_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// *****
// Port checker for the measurement register bank
// *****
module wmc_regs_chk
  import wmc_pkg::*;
#(
  parameter logic [4:0] CHIP_TYPE = 5'h11, // Arbitrary value
  parameter logic [2:0] CHIP_REV = 3'h1 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Measurements, enables and outputs
  input wire wmc_meas_t phase_meas,
  input wire wmc_meas_t cap_meas,
  input wire logic cap_wake_enable,
  input wire logic phase_wake_enable,
  input wire wmc_cfg_t phase_cfg_out,
  input wire wmc_cfg_t cap_cfg_out,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Decoded writes shared by several properties
  wire wr_cap = reg_write && reg_addr == 8'h3b;
  wire wr_mask = reg_write && reg_addr == 8'h41;

  rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  ident_rd_a: assert property (reg_read && reg_addr == 8'h3f |=>
    reg_rdata == {CHIP_TYPE, CHIP_REV}) else $error("identity read wrong");
  unmap_rd_a: assert property (reg_read && reg_addr == 8'h42 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cap_cfg_a: assert property (wr_cap |=> cap_cfg_out == $past(reg_wdata))
    else $error("cap config write lost");
  ph_cfg_a: assert property (reg_write && reg_addr == 8'h37 |=>
    phase_cfg_out == $past(reg_wdata)) else $error("phase config write lost");
  cfg_hold_a: assert property (!wr_cap |=> $stable(cap_cfg_out))
    else $error("cap config changed without write");
  mask_off_a: assert property (wr_mask && reg_wdata[1:0] == 2'h0 |=> !irq)
    else $error("irq high with mask clear");
  irq_cause_a: assert property ($rose(irq) |-> $past(wr_mask ||
    cap_meas.valid && cap_wake_enable || phase_meas.valid && phase_wake_enable))
    else $error("irq rose without cause");
endmodule // wmc_regs_chk

bind wmc_regs wmc_regs_chk #(.CHIP_TYPE(CHIP_TYPE), .CHIP_REV(CHIP_REV)) chk_i (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .phase_meas(phase_meas), .cap_meas(cap_meas), .cap_wake_enable(cap_wake_enable),
  .phase_wake_enable(phase_wake_enable), .phase_cfg_out(phase_cfg_out),
  .cap_cfg_out(cap_cfg_out), .irq(irq));
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
// *****
// Register bench
// *****
module tb
  import wmc_pkg::*;
;
  localparam logic [4:0] CT = 5'h0a; // Arbitrary value
  localparam logic [2:0] CR = 3'h3; // Arbitrary value
  logic clk, nrst, reg_write, reg_read, cap_wake_enable, phase_wake_enable, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, avg, exp;
  wmc_meas_t phase_meas, cap_meas;
  wmc_cfg_t phase_cfg_out, cap_cfg_out;
  int n_mismatch, n_checks, cyc, d;
  wmc_regs #(.CHIP_TYPE(CT), .CHIP_REV(CR)) DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .phase_meas(phase_meas), .cap_meas(cap_meas), .cap_wake_enable(cap_wake_enable),
    .phase_wake_enable(phase_wake_enable), .phase_cfg_out(phase_cfg_out),
    .cap_cfg_out(cap_cfg_out), .irq(irq));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard, far above the roughly 150 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] got);
    n_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, e, got);
    end
  endtask
  // Trailing edge keeps a following strobe out of this time step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, reg_rdata);
    @(posedge clk);
  endtask
  task automatic meas(input logic cap, input logic [7:0] v);
    if (cap) cap_meas <= '{1'b1, v};
    else phase_meas <= '{1'b1, v};
    @(posedge clk);
    cap_meas.valid <= 1'b0;
    phase_meas.valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    {reg_write, reg_read, cap_wake_enable, phase_wake_enable} = 4'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    cap_meas = '0;
    phase_meas = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values, then writes to read-only and unmapped places
    for (int a = 8'h37; a <= 8'h42; a++) begin
      exp = (a == 8'h3f) ? {CT, CR} : 8'h00;
      rd(a[7:0], exp);
      if (a inside {8'h39, 8'h3a, 8'h3d, 8'h3e, 8'h3f, 8'h42}) begin
        wr(a[7:0], 8'hff);
        rd(a[7:0], exp);
      end
    end
    wr(8'h38, 8'ha5);
    rd(8'h38, 8'ha5);
    wr(8'h3c, 8'h40);
    rd(8'h3c, 8'h40);
    $display("test registers done");
    // Threshold boundary, include bit, masking and clearing
    wr(8'h41, 8'h03);
    cap_wake_enable <= 1'b1;
    wr(8'h3b, 8'h28);
    meas(1'b1, 8'h42);
    chk("irq", 8'h00, {7'h0, irq});
    rd(8'h3d, 8'h10);
    meas(1'b1, 8'h43);
    chk("irq", 8'h01, {7'h0, irq});
    rd(8'h3e, 8'h43);
    rd(8'h3d, 8'h1c);
    wr(8'h41, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    wr(8'h41, 8'h03);
    wr(8'h40, 8'h02);
    chk("irq", 8'h00, {7'h0, irq});
    wr(8'h3b, 8'h20);
    meas(1'b1, 8'h50);
    rd(8'h3d, 8'h1c);
    $display("test threshold done");
    // Every weight code, last pass downward to catch rounding
    avg = 8'h1c;
    for (int w = 0; w < 5; w++) begin
      wr(8'h3b, {4'hf, 1'b1, w[1:0], 1'b1});
      exp = w[2] ? 8'h00 : 8'hfc;
      meas(1'b1, exp);
      d = int'(exp) - int'(avg);
      avg = avg + 8'(d >>> (w[1:0] + 2));
      rd(8'h3d, avg);
    end
    // Same value against running average, then against software reference
    wr(8'h40, 8'h03);
    wr(8'h3b, 8'h21);
    meas(1'b1, avg);
    rd(8'h40, 8'h00);
    wr(8'h3b, 8'h20);
    meas(1'b1, avg);
    rd(8'h40, 8'h02);
    wr(8'h40, 8'h02);
    cap_wake_enable <= 1'b0;
    meas(1'b1, 8'h00);
    rd(8'h40, 8'h00);
    $display("test averaging done");
    // Phase channel mirrors the capacitance fields
    phase_wake_enable <= 1'b1;
    wr(8'h37, 8'h28);
    meas(1'b0, 8'ha8);
    rd(8'h40, 8'h01);
    rd(8'h3a, 8'ha8);
    rd(8'h39, 8'h2a);
    $display("test phase done");
    results();
  end
endmodule // tb
`default_nettype wire
